// file: src/strp_pkg.sv
// Shared constants and types of the serial transmitter/receiver with parity.
// Assumes one system clock; bits run at one quarter of that clock.
package strp_pkg;

    // ------------------------------------------------------------------
    // Frame and sequencer
    // ------------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int TX_SH_W = 9;
    localparam int RX_CHAIN_W = 10;
    localparam logic [3:0] SEQ_LOAD = 4'h9;
    localparam logic [3:0] SEQ_LAST_DATA = 4'h2;
    localparam logic [3:0] SEQ_PARITY = 4'h1;
    localparam logic [3:0] SEQ_ZERO = 4'h0;

    // ------------------------------------------------------------------
    // Bit timing
    // ------------------------------------------------------------------
    localparam logic [1:0] TX_DIV_LAST = 2'h3;
    localparam logic [1:0] RX_PHASE_SAMPLE = 2'h1;
    localparam logic [1:0] PHASE_ZERO = 2'h0;
    localparam logic [1:0] PHASE_STEP = 2'h1;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_TXDATA = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    localparam logic [3:0] ADDR_RXDATA = 4'hc;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_SENSE_BIT = 1;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_READY_BIT = 1;
    localparam int ST_PERR_BIT = 2;
    localparam int ST_NEW_BIT = 3;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        TX_IDLE,
        TX_ARMED,
        TX_START,
        TX_SHIFT
    } strp_tx_state_type;

endpackage

// file: src/strp_rx_if.sv
// Link between the register side and the receiver core.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ns
interface strp_rx_if;
    logic parity_sense;
    logic [7:0] rx_word;
    logic rx_ready;
    logic rx_perr;
    logic rx_done;
    modport rx (input parity_sense, output rx_word, rx_ready, rx_perr, rx_done);
    modport host (output parity_sense, input rx_word, rx_ready, rx_perr, rx_done);
endinterface

// file: src/strp_rx.sv
// Shift register receiver with counter decode and parity check.
// Assumes serial_in is synchronous to clk_sys; one bit lasts four clocks.
`timescale 1ns/1ns
module strp_rx
    import strp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic serial_in,
    strp_rx_if.rx rif
);

    logic bit_timer_low_ff;
    logic bit_timer_high_ff;
    logic ready_ff;
    logic [RX_CHAIN_W-1:0] chain_ff;
    logic [3:0] seq_cnt_ff;
    logic [DATA_W-1:0] stage_word_ff;
    logic [DATA_W-1:0] word_ff;
    logic par_cnt_ff;
    logic par_rx_ff;
    logic perr_ff;
    logic done_ff;
    logic [1:0] timer;
    logic [1:0] nxt_timer;
    logic start_det;
    logic sample;
    logic first;
    logic data_sample;
    logic finish;

    assign timer = {bit_timer_high_ff, bit_timer_low_ff};
    assign start_det = ready_ff && !serial_in;
    assign sample = !ready_ff && (timer == RX_PHASE_SAMPLE);
    assign first = sample && (&chain_ff);
    assign data_sample = sample && !first && (seq_cnt_ff >= SEQ_LAST_DATA);
    assign finish = sample && !chain_ff[RX_CHAIN_W-1];

    // ------------------------------------------------------------------
    // Timing counter
    // ------------------------------------------------------------------
    always_comb begin
        if (ready_ff || finish) begin
            nxt_timer = PHASE_ZERO;
        end else begin
            nxt_timer = timer + PHASE_STEP;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            bit_timer_low_ff <= 1'b0;
            bit_timer_high_ff <= 1'b0;
        end else begin
            bit_timer_low_ff <= nxt_timer[0];
            bit_timer_high_ff <= nxt_timer[1];
        end
    end

    // ------------------------------------------------------------------
    // Ready register and shift chain
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ready_ff <= 1'b1;
            chain_ff <= '1;
        end else if (start_det) begin
            ready_ff <= 1'b0;
            chain_ff <= '1;
        end else if (sample) begin
            ready_ff <= finish;
            chain_ff <= {chain_ff[RX_CHAIN_W-2:0], serial_in};
        end
    end

    // ------------------------------------------------------------------
    // Bit sequencer and demultiplexed word
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            seq_cnt_ff <= SEQ_ZERO;
        end else if (first) begin
            seq_cnt_ff <= SEQ_LOAD;
        end else if (sample && seq_cnt_ff != SEQ_ZERO) begin
            seq_cnt_ff <= seq_cnt_ff - 4'h1;
        end
    end

    for (genvar i = 0; i < DATA_W; i++) begin : g_demux
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                stage_word_ff[i] <= 1'b0;
            end else if (data_sample && seq_cnt_ff == SEQ_LOAD - 4'(i)) begin
                stage_word_ff[i] <= serial_in;
            end
        end
    end

    // ------------------------------------------------------------------
    // Parity and completion
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            par_cnt_ff <= 1'b0;
            par_rx_ff <= 1'b0;
        end else if (first) begin
            par_cnt_ff <= 1'b0;
        end else if (data_sample && serial_in == rif.parity_sense) begin
            par_cnt_ff <= !par_cnt_ff;
        end else if (sample && seq_cnt_ff == SEQ_PARITY) begin
            par_rx_ff <= serial_in;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            word_ff <= '0;
            perr_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= finish;
            if (finish) begin
                word_ff <= stage_word_ff;
                perr_ff <= par_cnt_ff != par_rx_ff;
            end else if (start_det) begin
                perr_ff <= 1'b0;
            end
        end
    end

    assign rif.rx_word = word_ff;
    assign rif.rx_ready = ready_ff;
    assign rif.rx_perr = perr_ff;
    assign rif.rx_done = done_ff;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_gap3;
        !sample [*3] ##1 sample;
    endsequence

    property p_rx_first;
        start_det |-> ##1 !sample ##1 sample;
    endproperty
    a_rx_first: assert property (p_rx_first) else $error("first sample not two clocks on");

    property p_rx_period;
        sample && !finish |=> s_gap3;
    endproperty
    a_rx_period: assert property (p_rx_period) else $error("receive sample spacing wrong");

    property p_rx_idle;
        ready_ff && $past(ready_ff) |-> timer == PHASE_ZERO && $stable(word_ff);
    endproperty
    a_rx_idle: assert property (p_rx_idle) else $error("idle receiver not quiet");

    property p_rx_perr;
        finish |=> perr_ff == ($past(par_cnt_ff) != $past(par_rx_ff));
    endproperty
    a_rx_perr: assert property (p_rx_perr) else $error("parity compare wrong");

endmodule

// file: src/strp_top.sv
// Serial transmitter and receiver with parity behind an Avalon-MM slave.
// Assumes a single clk_sys and a master that holds requests during waitrequest.
//
// Chosen here: the Avalon-MM register port and the address map.
`timescale 1ns/1ns
module strp_top
    import strp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic serial_in,
    output logic serial_out
);

    strp_rx_if rif ();

    logic wait_ff;
    logic [31:0] rdata_ff;
    logic sense_ff;
    logic start_req_ff;
    logic [DATA_W-1:0] tx_word_ff;
    logic rx_new_ff;
    strp_tx_state_type state_ff;
    logic [1:0] div_ff;
    logic serial_line_out_reg_ff;
    logic [TX_SH_W-1:0] sh_ff;
    logic [3:0] seq_cnt_ff;
    logic par_cnt_ff;
    logic req;
    logic wr_take;
    logic tx_sample;
    logic tx_done;
    logic [31:0] nxt_rdata;

    assign req = avs_read || avs_write;
    assign wr_take = avs_write && !wait_ff;

    // ------------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wait_ff <= 1'b1;
        end else begin
            wait_ff <= !(req && wait_ff);
        end
    end

    always_comb begin
        nxt_rdata = RD_ZERO;
        case (avs_address)
            ADDR_CTRL: begin
                nxt_rdata[CTRL_SENSE_BIT] = sense_ff;
            end
            ADDR_TXDATA: begin
                nxt_rdata[DATA_W-1:0] = tx_word_ff;
            end
            ADDR_STATUS: begin
                nxt_rdata[ST_BUSY_BIT] = state_ff != TX_IDLE;
                nxt_rdata[ST_READY_BIT] = rif.rx_ready;
                nxt_rdata[ST_PERR_BIT] = rif.rx_perr;
                nxt_rdata[ST_NEW_BIT] = rx_new_ff;
            end
            ADDR_RXDATA: begin
                nxt_rdata[DATA_W-1:0] = rif.rx_word;
            end
            default: begin
                nxt_rdata = RD_ZERO;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata_ff <= RD_ZERO;
        end else if (avs_read && wait_ff) begin
            rdata_ff <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sense_ff <= 1'b0;
            start_req_ff <= 1'b0;
        end else begin
            start_req_ff <= wr_take && avs_address == ADDR_CTRL
                            && avs_writedata[CTRL_START_BIT];
            if (wr_take && avs_address == ADDR_CTRL) begin
                sense_ff <= avs_writedata[CTRL_SENSE_BIT];
            end
        end
    end

    // Word held in a register so the host side cannot disturb the load
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tx_word_ff <= '0;
        end else if (wr_take && avs_address == ADDR_TXDATA && state_ff == TX_IDLE) begin
            tx_word_ff <= avs_writedata[DATA_W-1:0];
        end
    end

    // Sticky new-word flag; a completion beats a clear
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rx_new_ff <= 1'b0;
        end else if (rif.rx_done) begin
            rx_new_ff <= 1'b1;
        end else if (wr_take && avs_address == ADDR_STATUS && avs_writedata[ST_NEW_BIT]) begin
            rx_new_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Transmit sample pulse
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            div_ff <= PHASE_ZERO;
        end else begin
            div_ff <= div_ff + PHASE_STEP;
        end
    end

    assign tx_sample = div_ff == TX_DIV_LAST;
    assign tx_done = state_ff == TX_SHIFT && tx_sample && seq_cnt_ff == SEQ_ZERO
                     && serial_line_out_reg_ff && sh_ff == '0;

    // ------------------------------------------------------------------
    // Transmit sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_ff <= TX_IDLE;
        end else begin
            case (state_ff)
                TX_IDLE: begin
                    if (start_req_ff) begin
                        state_ff <= TX_ARMED;
                    end
                end
                TX_ARMED: begin
                    if (tx_sample) begin
                        state_ff <= TX_START;
                    end
                end
                TX_START: begin
                    if (tx_sample) begin
                        state_ff <= TX_SHIFT;
                    end
                end
                TX_SHIFT: begin
                    if (tx_done) begin
                        state_ff <= TX_IDLE;
                    end
                end
                default: begin
                    state_ff <= TX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            serial_line_out_reg_ff <= 1'b1;
        end else if (state_ff == TX_IDLE) begin
            serial_line_out_reg_ff <= !start_req_ff;
        end else if (tx_sample && state_ff == TX_ARMED) begin
            serial_line_out_reg_ff <= 1'b0;
        end else if (tx_sample && state_ff == TX_START) begin
            serial_line_out_reg_ff <= tx_word_ff[0];
        end else if (tx_sample && state_ff == TX_SHIFT && !tx_done) begin
            // Closing sample leaves the stop level on the line
            if (seq_cnt_ff == SEQ_LAST_DATA) begin
                serial_line_out_reg_ff <= par_cnt_ff;
            end else begin
                serial_line_out_reg_ff <= sh_ff[0];
            end
        end
    end

    // Stop bit on top, parity slot below it, remaining data bits below
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sh_ff <= '0;
        end else if (state_ff == TX_IDLE) begin
            sh_ff <= '0;
        end else if (tx_sample && state_ff == TX_START) begin
            sh_ff <= {1'b1, 1'b0, tx_word_ff[DATA_W-1:1]};
        end else if (tx_sample && state_ff == TX_SHIFT) begin
            sh_ff <= {1'b0, sh_ff[TX_SH_W-1:1]};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            seq_cnt_ff <= SEQ_ZERO;
        end else if (state_ff == TX_IDLE) begin
            seq_cnt_ff <= SEQ_ZERO;
        end else if (tx_sample && state_ff == TX_START) begin
            seq_cnt_ff <= SEQ_LOAD;
        end else if (tx_sample && state_ff == TX_SHIFT && seq_cnt_ff != SEQ_ZERO) begin
            seq_cnt_ff <= seq_cnt_ff - 4'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            par_cnt_ff <= 1'b0;
        end else if (state_ff == TX_IDLE || tx_done) begin
            par_cnt_ff <= 1'b0;
        end else if (tx_sample && state_ff == TX_START) begin
            par_cnt_ff <= tx_word_ff[0] == sense_ff;
        end else if (tx_sample && state_ff == TX_SHIFT && seq_cnt_ff > SEQ_LAST_DATA
                     && sh_ff[0] == sense_ff) begin
            par_cnt_ff <= !par_cnt_ff;
        end
    end

    assign rif.parity_sense = sense_ff;

    strp_rx u_rx (
        .clk_sys(clk_sys),
        .rst(rst),
        .serial_in(serial_in),
        .rif(rif)
    );

    assign avs_readdata = rdata_ff;
    assign avs_waitrequest = wait_ff;
    assign serial_out = serial_line_out_reg_ff;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_tx_gap3;
        !tx_sample [*3] ##1 tx_sample;
    endsequence

    property p_tx_idle;
        state_ff == TX_IDLE && !$past(start_req_ff) |->
            serial_out && sh_ff == '0 && seq_cnt_ff == SEQ_ZERO && !par_cnt_ff;
    endproperty
    a_tx_idle: assert property (p_tx_idle) else $error("idle transmitter not at rest");

    property p_tx_start;
        state_ff == TX_IDLE && start_req_ff |=> !serial_out [*4];
    endproperty
    a_tx_start: assert property (p_tx_start) else $error("start bit not driven low");

    property p_tx_rate;
        tx_sample |=> s_tx_gap3;
    endproperty
    a_tx_rate: assert property (p_tx_rate) else $error("sample pulse not quarter rate");

    property p_tx_load;
        state_ff == TX_START && tx_sample |=>
            sh_ff[TX_SH_W-1] && serial_out == $past(tx_word_ff[0]) && seq_cnt_ff == SEQ_LOAD;
    endproperty
    a_tx_load: assert property (p_tx_load) else $error("load step wrong");

    property p_tx_shift;
        state_ff == TX_SHIFT && tx_sample |=> !sh_ff[TX_SH_W-1] && serial_out == ($past(tx_done)
            ? 1'b1 : ($past(seq_cnt_ff) == SEQ_LAST_DATA) ? $past(par_cnt_ff) : $past(sh_ff[0]));
    endproperty
    a_tx_shift: assert property (p_tx_shift) else $error("shift step wrong");

    property p_tx_end;
        state_ff == TX_SHIFT && tx_sample && seq_cnt_ff == SEQ_ZERO |=>
            state_ff == TX_IDLE && serial_out;
    endproperty
    a_tx_end: assert property (p_tx_end) else $error("transmission did not end");

    property p_tx_len;
        state_ff == TX_START && tx_sample |-> ##41 state_ff == TX_IDLE && serial_out;
    endproperty
    a_tx_len: assert property (p_tx_len) else $error("frame length wrong");

    property p_bus_wait;
        req && wait_ff |=> !wait_ff ##1 wait_ff;
    endproperty
    a_bus_wait: assert property (p_bus_wait) else $error("waitrequest not one cycle");

    property p_tx_arm;
        state_ff == TX_IDLE && start_req_ff |=> state_ff == TX_ARMED;
    endproperty
    a_tx_arm: assert property (p_tx_arm) else $error("start request not taken");

    property p_tx_parity;
        state_ff == TX_SHIFT && tx_sample && seq_cnt_ff == SEQ_LAST_DATA |=>
            serial_out == $past(par_cnt_ff);
    endproperty
    a_tx_parity: assert property (p_tx_parity) else $error("parity bit not sent");

    property p_tx_par_step;
        state_ff == TX_SHIFT && tx_sample && seq_cnt_ff > SEQ_LAST_DATA |=>
            par_cnt_ff == ($past(par_cnt_ff) ^ ($past(sh_ff[0]) == $past(sense_ff)));
    endproperty
    a_tx_par_step: assert property (p_tx_par_step) else $error("parity count wrong");

    property p_tx_seq_step;
        state_ff == TX_SHIFT && tx_sample && seq_cnt_ff != SEQ_ZERO |=>
            seq_cnt_ff == $past(seq_cnt_ff) - 4'h1;
    endproperty
    a_tx_seq_step: assert property (p_tx_seq_step) else $error("sequencer step wrong");

    property p_tx_word_hold;
        state_ff != TX_IDLE |=> $stable(tx_word_ff);
    endproperty
    a_tx_word_hold: assert property (p_tx_word_hold) else $error("word changed in frame");

    property p_rx_new;
        rif.rx_done |=> rx_new_ff;
    endproperty
    a_rx_new: assert property (p_rx_new) else $error("new word flag not set");

endmodule

// file: testbench/strp_line_partner.sv
// Remote serial party: sends frames into the receiver, captures transmitter frames.
// Assumes clk_sys is the block's clock; bits last four clocks.
`timescale 1ns/1ns
module strp_line_partner (
    input wire logic clk_sys,
    input wire logic serial_out,
    output logic serial_in,
    output logic [7:0] cap_word,
    output logic cap_par,
    output logic cap_stop,
    output int cap_cnt
);
    logic [9:0] sh;

    // Start low, data LSB first, parity, stop high; four clocks a bit
    task automatic send_frame(input logic [7:0] d, input logic p);
        logic [10:0] fr;
        fr = {1'b1, p, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            serial_in <= fr[i];
            repeat (4) @(posedge clk_sys);
        end
    endtask

    // Sample mid-cycle; start bit is 5..8 clocks, so bit0 is settled 8.5 after
    initial begin
        serial_in = 1'b1;
        cap_cnt = 0;
        forever begin
            @(negedge clk_sys);
            if (serial_out === 1'b0) begin
                repeat (8) @(negedge clk_sys);
                for (int k = 0; k < 10; k++) begin
                    sh[k] = serial_out;
                    if (k < 9)
                        repeat (4) @(negedge clk_sys);
                end
                cap_word = sh[7:0];
                cap_par = sh[8];
                cap_stop = sh[9];
                cap_cnt = cap_cnt + 1;
            end
        end
    end
endmodule

// file: testbench/testbench.sv
// Self-checking bench: Avalon-MM master plus a serial partner on both lines.
// Assumes a 20 MHz clk_sys and the register map of strp_pkg.
`timescale 1ns/1ns
module testbench;
    import strp_pkg::*;
    logic clk_sys, rst, avs_read, avs_write, avs_waitrequest, serial_in, serial_out;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd, seed;
    logic [7:0] cap_word, d;
    logic cap_par, cap_stop;
    int cap_cnt, n_errors, checks_done;

    strp_top strp_top_i (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .serial_in(serial_in), .serial_out(serial_out));
    strp_line_partner strp_line_partner_i (.clk_sys(clk_sys), .serial_out(serial_out),
        .serial_in(serial_in), .cap_word(cap_word), .cap_par(cap_par),
        .cap_stop(cap_stop), .cap_cnt(cap_cnt));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    // Count of bits equal to the sense, modulo two
    function automatic logic par(input logic [7:0] v, input logic s);
        return s ? ^v : ^(~v);
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= v;
        avs_write <= we;
        avs_read <= ~we;
        do begin
            @(posedge clk_sys);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic tx_one(input logic [7:0] v, input logic s);
        int n;
        n = cap_cnt;
        bus(1'b1, ADDR_CTRL, {30'h0, s, 1'b0});
        bus(1'b1, ADDR_TXDATA, {24'h0, v});
        bus(1'b1, ADDR_CTRL, {30'h0, s, 1'b1});
        bus(1'b1, ADDR_TXDATA, {24'h0, ~v});
        bus(1'b0, ADDR_TXDATA, 32'h0);
        check("tx_held", rd, {24'h0, v});
        bus(1'b0, ADDR_CTRL, 32'h0);
        check("ctrl_sense", rd, {30'h0, s, 1'b0});
        bus(1'b0, ADDR_STATUS, 32'h0);
        check("tx_busy", {31'h0, rd[ST_BUSY_BIT]}, 32'h1);
        for (int k = 0; k < 200 && cap_cnt == n; k++)
            @(posedge clk_sys);
        check("tx_frames", cap_cnt, n + 1);
        check("tx_word", {24'h0, cap_word}, {24'h0, v});
        check("tx_parity", {31'h0, cap_par}, {31'h0, par(v, s)});
        check("tx_stop", {31'h0, cap_stop}, 32'h1);
        for (int k = 0; k < 20 && rd[ST_BUSY_BIT] !== 1'b0; k++)
            bus(1'b0, ADDR_STATUS, 32'h0);
        check("tx_idle", {31'h0, rd[ST_BUSY_BIT]}, 32'h0);
        check("tx_done_line", {31'h0, serial_out}, 32'h1);
    endtask

    task automatic rx_one(input logic [7:0] v, input logic s, input logic flip);
        @(posedge clk_sys);
        strp_line_partner_i.send_frame(v, par(v, s) ^ flip);
        bus(1'b0, ADDR_STATUS, 32'h0);
        check("rx_status", rd, {28'h0, 1'b1, flip, 2'b10});
        bus(1'b0, ADDR_RXDATA, 32'h0);
        check("rx_word", rd, {24'h0, v});
        bus(1'b1, ADDR_STATUS, 32'h8);
        bus(1'b0, ADDR_STATUS, 32'h0);
        check("rx_cleared", rd, {29'h0, flip, 2'b10});
    endtask

    task automatic report_and_stop;
        if (n_errors == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (8000) @(posedge clk_sys);
        n_errors++;
        report_and_stop;
    end

    initial begin
        rst = 1'b1;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        n_errors = 0;
        checks_done = 0;
        seed = 32'h2c083c9c;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        bus(1'b0, ADDR_STATUS, 32'h0);
        check("status_reset", rd, 32'h0000_0002);
        check("line_idle", {31'h0, serial_out}, 32'h1);
        bus(1'b0, 4'h2, 32'h0);
        check("unmapped", rd, RD_ZERO);
        for (int i = 0; i < 12; i++) begin
            seed = xs(seed);
            d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : seed[7:0];
            tx_one(d, i[0]);
            rx_one(~d, i[0], (i % 3) == 2);
        end
        report_and_stop;
    end
endmodule
